//--- hw/inventory_read_extended_handler.sv
/*
  Inventory-with-data command handler: decides whether and how the label
  answers the inventory-read, fast inventory-read and alarm-enable commands.
  Assumes software loads a decoded request over APB and strobes it; the
  frame encoder reads the reply plan from the result register and ports.
*/
`timescale 1ns/10ps

//Contract
//- Mask-length top bit selects extended mode
//- Inventory flag: answer only READY/SELECTED (code: only PQUIET answers if extended with option bits6/7 both set)
//- Option bit1 filters on alarm mode
//- Option bit2 truncated or full identifier
//- Option bit5 skips data blocks
//- Option bits6/7 choose post-reply state
//- Option flag includes or drops identifier
//- Reply: flags, identifier, blocks, CRC
//- Truncated length from slots and mask
//- Same slotting and timing as inventory
//- Addressed/selected uses non-inventory flag meanings
//- Addressed/selected acts as block read
//- No AFI; answer first slot only
//- Fast A1h behaves like inventory-read
//- Fast variant doubles return rate
//- Fast keeps forward rate and delay
//- Fast variant single subcarrier only
//- A2h enables alarm unless locked
//- Protected alarm needs prior password
//- Alarm-enable any option, write timing
//- Return block count plus one
//- Stop at highest user block
module inventory_read_extended_handler
  import inv_read_pkg::*;
#(
  parameter logic [7:0] LAST_USER_BLOCK = RST_LAST_BLOCK
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output reply_s reply,
  output logic reply_valid,
  output logic [1:0] tag_state_code
);

  request_s req_r;
  logic [63:0] uid_r;
  logic [7:0] cfg_r;
  logic alarm_mode_r;
  tag_state_e state_r;
  tag_state_e state_nxt;
  reply_s reply_r;
  reply_s reply_nxt;
  logic valid_r;
  logic go;
  logic wr_en;
  logic rd_ok;

  // CFG bits: 0 alarm locked, 1 alarm protected, 2 password given,
  // 3 sixteen slots, 4 selected, 5 addressed match; bits 6/7 set state
  logic alarm_locked;
  logic alarm_protected;
  logic password_ok;
  logic sixteen_slots;

  assign alarm_locked = cfg_r[0];
  assign alarm_protected = cfg_r[1];
  assign password_ok = cfg_r[2];
  assign sixteen_slots = cfg_r[3];

  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    case (paddr)
      REG_CTRL, REG_REQ0, REG_REQ1, REG_UID_LO, REG_UID_HI, REG_CFG,
      REG_STATUS, REG_RESULT: rd_ok = 1'b1;
      default: rd_ok = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !rd_ok;
  assign go = wr_en && (paddr == REG_CTRL) && pstrb[0] && pwdata[0];

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Request registers
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req_r <= '0;
    end else if (wr_en && paddr == REG_REQ0) begin
      {req_r.flags, req_r.cmd, req_r.mask_len, req_r.ext_opt} <=
        merge({req_r.flags, req_r.cmd, req_r.mask_len, req_r.ext_opt}, pwdata, pstrb);
    end else if (wr_en && paddr == REG_REQ1) begin
      {req_r.first_blk, req_r.blk_count} <=
        16'(merge({16'h0000, req_r.first_blk, req_r.blk_count}, pwdata, pstrb));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      uid_r <= '0;
    end else if (wr_en && paddr == REG_UID_LO) begin
      uid_r[31:0] <= merge(uid_r[31:0], pwdata, pstrb);
    end else if (wr_en && paddr == REG_UID_HI) begin
      uid_r[63:32] <= merge(uid_r[63:32], pwdata, pstrb);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_r <= '0;
    end else if (wr_en && paddr == REG_CFG && pstrb[0]) begin
      cfg_r <= pwdata[7:0];
    end
  end

  // Decode of the current request
  logic extended;
  logic inv_flag;
  logic opt_flag;
  logic is_read;
  logic is_fast;
  logic [6:0] mlen;
  logic [7:0] id_bits;
  logic [3:0] id_bytes;
  logic [8:0] want_blocks;
  logic [8:0] avail_blocks;
  logic state_ok;
  logic filter_ok;
  logic [1:0] quiet_sel;

  assign extended = req_r.mask_len[MASKLEN_EXT_BIT];
  assign mlen = req_r.mask_len[6:0];
  assign inv_flag = req_r.flags[FLG_INVENTORY];
  assign opt_flag = req_r.flags[FLG_OPTION];
  assign is_fast = req_r.cmd == CMD_FAST_INV_READ;
  assign is_read = (req_r.cmd == CMD_INV_READ) || is_fast;
  assign quiet_sel = {req_r.ext_opt[OPT_PQUIET], req_r.ext_opt[OPT_QUIET]};

  // Truncated identifier length, rounded up to whole bytes
  always_comb begin
    logic [7:0] base;
    base = sixteen_slots ? 8'(UID_BITS - SLOT_BITS) : 8'(UID_BITS);
    id_bits = ({1'b0, mlen} >= base) ? 8'h00 : base - {1'b0, mlen};
    id_bytes = 4'((id_bits + 8'h07) >> 3);
  end

  // Block span, clipped at the top of user memory
  assign want_blocks = {1'b0, req_r.blk_count} + 9'h001;
  assign avail_blocks = (req_r.first_blk > LAST_USER_BLOCK) ? 9'h000 :
                        {1'b0, LAST_USER_BLOCK} - {1'b0, req_r.first_blk} + 9'h001;

  always_comb begin
    if (inv_flag) begin
      // Persistent-quiet tags only join when both quiet bits ask for them
      if (extended && quiet_sel == 2'b11) begin
        state_ok = state_r == TS_PQUIET;
      end else begin
        state_ok = (state_r == TS_READY) || (state_r == TS_SELECTED);
      end
    end else begin
      // Addressed or selected: the far side chose this tag explicitly
      state_ok = cfg_r[5] || (cfg_r[4] && state_r == TS_SELECTED);
    end
    filter_ok = !(extended && req_r.ext_opt[OPT_ALARM_FILTER]) || alarm_mode_r;
  end

  // Reply planning and state change
  always_comb begin
    reply_nxt = '0;
    state_nxt = state_r;
    reply_nxt.fast = is_fast;
    reply_nxt.high_rate = req_r.flags[FLG_RATE];
    reply_nxt.single_subcarrier = is_fast;
    if (is_read) begin
      reply_nxt.respond = state_ok && filter_ok;
      reply_nxt.first_slot_only = !inv_flag;
      reply_nxt.first_blk = req_r.first_blk;
      // Same slotting and reply timing as inventory; encoder owns them
      if (extended && req_r.ext_opt[OPT_SKIP_DATA]) begin
        reply_nxt.n_blocks = 9'h000;
      end else begin
        reply_nxt.n_blocks = (want_blocks < avail_blocks) ? want_blocks : avail_blocks;
      end
      if (!opt_flag || !inv_flag) begin
        reply_nxt.id_bytes = 4'h0;
      end else if (extended && req_r.ext_opt[OPT_FULL_ID]) begin
        reply_nxt.id_bytes = 4'h8;
      end else begin
        reply_nxt.id_bytes = id_bytes;
      end
      if (reply_nxt.respond && extended) begin
        case (quiet_sel)
          2'b01: state_nxt = TS_QUIET;
          2'b10: state_nxt = TS_PQUIET;
          default: state_nxt = state_r;
        endcase
      end
    end else if (req_r.cmd == CMD_ALARM_ENABLE) begin
      reply_nxt.respond = 1'b1;
      reply_nxt.write_timing = 1'b1;
      reply_nxt.error = alarm_locked || (alarm_protected && !password_ok);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reply_r <= '0;
      valid_r <= 1'b0;
    end else begin
      valid_r <= go;
      if (go) begin
        reply_r <= reply_nxt;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= TS_READY;
    end else if (wr_en && paddr == REG_CFG && pstrb[0] && pwdata[6]) begin
      // Software forces the state from the outer state machine
      case (pwdata[7])
        1'b1: state_r <= TS_SELECTED;
        default: state_r <= TS_READY;
      endcase
    end else if (go) begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      alarm_mode_r <= 1'b0;
    end else if (go && req_r.cmd == CMD_ALARM_ENABLE && !reply_nxt.error) begin
      alarm_mode_r <= 1'b1;
    end
  end

  always_comb begin
    case (state_r)
      TS_SELECTED: tag_state_code = 2'h1;
      TS_QUIET: tag_state_code = 2'h2;
      TS_PQUIET: tag_state_code = 2'h3;
      default: tag_state_code = 2'h0;
    endcase
  end

  assign reply = reply_r;
  assign reply_valid = valid_r;

  always_comb begin
    prdata = 32'h00000000;
    if (psel && !pwrite) begin
      case (paddr)
        REG_REQ0: prdata = {req_r.flags, req_r.cmd, req_r.mask_len, req_r.ext_opt};
        REG_REQ1: prdata = {16'h0000, req_r.first_blk, req_r.blk_count};
        REG_UID_LO: prdata = uid_r[31:0];
        REG_UID_HI: prdata = uid_r[63:32];
        REG_CFG: prdata = {24'h000000, cfg_r};
        REG_STATUS: prdata = {27'h0000000, alarm_mode_r, valid_r, 1'b0, tag_state_code};
        // 3 + 8 + 9 + 4 + 4 + 4 bits: flags sit in the low nibble
        REG_RESULT: prdata = {3'h0, reply_r.first_blk, reply_r.n_blocks,
                              reply_r.id_bytes, 4'h0, reply_r.respond, reply_r.error,
                              reply_r.fast, reply_r.first_slot_only};
        default: prdata = 32'h00000000;
      endcase
    end
  end

endmodule // inventory_read_extended_handler

//--- hw/inv_read_pkg.sv
/*
  Package for the inventory-with-data command handler: register map, field
  positions, reset values, command codes, option bits and shared types.
  Assumes a 32-bit APB master and a frame decoder/encoder around the block.
*/
package inv_read_pkg;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_REQ0 = 8'h04;
  localparam logic [7:0] REG_REQ1 = 8'h08;
  localparam logic [7:0] REG_UID_LO = 8'h0C;
  localparam logic [7:0] REG_UID_HI = 8'h10;
  localparam logic [7:0] REG_CFG = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_RESULT = 8'h1C;

  // Command codes
  localparam logic [7:0] CMD_INV_READ = 8'hA0;
  localparam logic [7:0] CMD_FAST_INV_READ = 8'hA1;
  localparam logic [7:0] CMD_ALARM_ENABLE = 8'hA2;

  // Request flag bit positions (0-based)
  localparam int FLG_RATE = 1;
  localparam int FLG_INVENTORY = 2;
  localparam int FLG_OPTION = 6;

  // Extended option bit positions (0-based; bit 1 of the byte is index 0)
  localparam int OPT_ALARM_FILTER = 0;
  localparam int OPT_FULL_ID = 1;
  localparam int OPT_SKIP_DATA = 4;
  localparam int OPT_QUIET = 5;
  localparam int OPT_PQUIET = 6;
  localparam int MASKLEN_EXT_BIT = 7;

  // Slot-number bits taken out of the identifier with sixteen slots
  localparam int UID_BITS = 64;
  localparam int SLOT_BITS = 4;

  // Reset values
  localparam logic [7:0] RST_LAST_BLOCK = 8'h4F;

  typedef enum {
    TS_READY,
    TS_SELECTED,
    TS_QUIET,
    TS_PQUIET
  } tag_state_e;

  typedef enum logic [1:0] {
    LR_STANDARD,
    LR_DOUBLE
  } link_rate_e;

  // Decoded request, as placed by software in the request registers
  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] cmd;
    logic [7:0] mask_len;
    logic [7:0] ext_opt;
    logic [7:0] first_blk;
    logic [7:0] blk_count;
  } request_s;

  // Reply plan handed to the frame encoder
  typedef struct packed {
    logic respond;
    logic error;
    logic [3:0] id_bytes;
    logic [7:0] first_blk;
    logic [8:0] n_blocks;
    logic fast;
    logic high_rate;
    logic single_subcarrier;
    logic first_slot_only;
    logic write_timing;
  } reply_s;

endpackage

//--- testbench/inv_read_monitor.sv
/* Checker on the handler ports: APB answers and reply plan timing.
   Assumes a bind from the bench top file. */
`timescale 1ns/10ps
module inv_read_monitor
  import inv_read_pkg::*;
#(
  parameter logic [7:0] LAST_USER_BLOCK = RST_LAST_BLOCK
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire reply_s reply,
  input wire logic reply_valid
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  wire go = psel && penable && pwrite && paddr == REG_CTRL && pwdata[0];
  wire bad = psel && paddr > REG_RESULT;
  AST_VALID: assert property (go |=> reply_valid)
    else $error("no reply after go");
  AST_CAUSE: assert property (reply_valid |-> $past(go))
    else $error("reply without go");
  AST_HOLD: assert property (!reply_valid |-> $stable(reply))
    else $error("reply plan changed without go");
  AST_SUB: assert property (reply_valid && reply.fast |-> reply.single_subcarrier)
    else $error("fast reply not single subcarrier");
  AST_IDB: assert property (reply_valid |-> reply.id_bytes <= 4'h8)
    else $error("identifier longer than 8 bytes");
  AST_END: assert property (reply_valid && reply.respond && !reply.error |->
    reply.n_blocks == 9'h000 ||
    10'(reply.first_blk) + 10'(reply.n_blocks) <= 10'(LAST_USER_BLOCK) + 10'h1)
    else $error("blocks beyond user memory");
  AST_WT: assert property (reply_valid && reply.write_timing |->
    !reply.fast && reply.n_blocks == 9'h0)
    else $error("write timing reply carries data");
  AST_ERR: assert property (bad && penable |-> pslverr && pready)
    else $error("unmapped access not refused");
  AST_RDZ: assert property (bad && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
endmodule // inv_read_monitor

//--- testbench/reader_model.sv
/* Reader-side request source: loads decoded frames over APB.
   Assumes the bench supplies the clock and holds reset. */
`timescale 1ns/10ps
module reader_model
  import inv_read_pkg::*;
(
  input wire logic sys_clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb
);
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (!pready);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle data is junk, not a held copy
    pwdata <= ~d;
  endtask
  task automatic send(input logic [7:0] f, c, m, o, fb, bc, cfg);
    logic [31:0] r;
    logic e;
    logic [7:0] oo;
    oo = o & 8'h73;
    xfer(1'b1, REG_REQ0, {f, c, m, oo}, r, e);
    xfer(1'b1, REG_REQ1, oo[OPT_SKIP_DATA] ? 32'h0 : {16'h0, fb, bc}, r, e);
    xfer(1'b1, REG_CFG, {24'h0, cfg}, r, e);
    xfer(1'b1, REG_CTRL, 32'h1, r, e);
    @(posedge sys_clk);
  endtask
endmodule // reader_model

//--- testbench/inventory_read_extended_handler_tb.sv
/* Self-checking bench for the inventory-with-data handler.
   Assumes the package and design files are compiled first. */
`timescale 1ns/10ps
module inventory_read_extended_handler_tb
  import inv_read_pkg::*;
;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, reply_valid, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb;
  logic [1:0] tag_state_code;
  reply_s reply;
  int fail_count = 0;
  int checks = 0;
  always #10 sys_clk = ~sys_clk;
  inventory_read_extended_handler #(.LAST_USER_BLOCK(8'h4F)) i_inventory_read_extended_handler (
    .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .reply, .reply_valid, .tag_state_code);
  reader_model i_reader_model (.sys_clk, .pready, .prdata, .pslverr,
    .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb);
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d fails %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic rst();
    sys_rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
  endtask
  task automatic go(input logic [7:0] f, c, m, o, fb, bc, cfg);
    i_reader_model.send(f, c, m, o, fb, bc, cfg);
    chk("valid", 16'h1, 16'(reply_valid));
  endtask
  task automatic t_bus();
    i_reader_model.xfer(1'b0, REG_STATUS, 32'h0, rdat, err);
    chk("status", 16'h0, rdat[15:0]);
    i_reader_model.xfer(1'b1, 8'h20, 32'hFFFF, rdat, err);
    chk("slverr", 16'h1, 16'(err));
    i_reader_model.xfer(1'b0, 8'h20, 32'h0, rdat, err);
    chk("rd_unmapped", 16'h0, rdat[15:0]);
    go(8'h04, 8'h20, 8'h80, 8'h0, 8'h0, 8'h0, 8'h0);
    chk("bad_cmd", 16'h0, 16'(reply.respond));
  endtask
  task automatic t_ext();
    go(8'h44, 8'hA0, 8'h9E, 8'h0, 8'h10, 8'h02, 8'h08);
    chk("respond", 16'h1, 16'(reply.respond));
    chk("id16", 16'h4, 16'(reply.id_bytes));
    chk("nblk", 16'h3, 16'(reply.n_blocks));
    chk("first", 16'h10, 16'(reply.first_blk));
    chk("stay", 16'h0, 16'(tag_state_code));
    i_reader_model.xfer(1'b0, REG_RESULT, 32'h0, rdat, err);
    chk("res_id", 16'h4, 16'(rdat[11:8]));
    chk("res_blk", 16'h3, 16'(rdat[20:12]));
    chk("res_rsp", 16'h1, 16'(rdat[3]));
    go(8'h44, 8'hA0, 8'h9E, 8'h0, 8'h10, 8'h02, 8'h0);
    chk("id1", 16'h5, 16'(reply.id_bytes));
    go(8'h44, 8'hA0, 8'h9E, 8'h02, 8'h10, 8'h02, 8'h0);
    chk("idfull", 16'h8, 16'(reply.id_bytes));
    go(8'h04, 8'hA0, 8'h9E, 8'h02, 8'h10, 8'h02, 8'h0);
    chk("noid", 16'h0, 16'(reply.id_bytes));
    go(8'h04, 8'hA0, 8'h80, 8'h10, 8'h10, 8'h02, 8'h0);
    chk("skip", 16'h0, 16'(reply.n_blocks));
    go(8'h04, 8'hA0, 8'h80, 8'h0, 8'h4E, 8'h05, 8'h0);
    chk("clip", 16'h2, 16'(reply.n_blocks));
  endtask
  task automatic t_alarm();
    go(8'h04, 8'hA0, 8'h80, 8'h01, 8'h0, 8'h0, 8'h0);
    chk("filt_off", 16'h0, 16'(reply.respond));
    go(8'h00, 8'hA2, 8'h0, 8'h0, 8'h0, 8'h0, 8'h01);
    chk("locked", 16'h1, 16'(reply.error));
    i_reader_model.xfer(1'b0, REG_STATUS, 32'h0, rdat, err);
    chk("lock_off", 16'h0, 16'(rdat[4]));
    go(8'h00, 8'hA2, 8'h0, 8'h0, 8'h0, 8'h0, 8'h02);
    chk("nopass", 16'h1, 16'(reply.error));
    go(8'h40, 8'hA2, 8'h0, 8'h0, 8'h0, 8'h0, 8'h06);
    chk("enable", 16'h0, 16'(reply.error));
    chk("wtime", 16'h1, 16'(reply.write_timing));
    i_reader_model.xfer(1'b0, REG_STATUS, 32'h0, rdat, err);
    chk("alarm", 16'h1, 16'(rdat[4]));
    go(8'h04, 8'hA0, 8'h80, 8'h01, 8'h0, 8'h0, 8'h0);
    chk("filt_on", 16'h1, 16'(reply.respond));
  endtask
  task automatic t_quiet();
    rst();
    go(8'h04, 8'hA0, 8'h80, 8'h20, 8'h0, 8'h0, 8'h0);
    chk("quiet", 16'h2, 16'(tag_state_code));
    go(8'h04, 8'hA0, 8'h80, 8'h0, 8'h0, 8'h0, 8'h0);
    chk("q_silent", 16'h0, 16'(reply.respond));
    rst();
    go(8'h04, 8'hA0, 8'h80, 8'h40, 8'h0, 8'h0, 8'h0);
    chk("pquiet", 16'h3, 16'(tag_state_code));
    go(8'h04, 8'hA0, 8'h80, 8'h60, 8'h0, 8'h0, 8'h0);
    chk("pq_only", 16'h1, 16'(reply.respond));
    rst();
    go(8'h04, 8'hA0, 8'h80, 8'h60, 8'h0, 8'h0, 8'h0);
    chk("rdy_skip", 16'h0, 16'(reply.respond));
  endtask
  task automatic t_fast_addr();
    go(8'h06, 8'hA1, 8'h80, 8'h0, 8'h0, 8'h0, 8'h0);
    chk("fast", 16'h1, 16'(reply.fast));
    chk("hi_rate", 16'h1, 16'(reply.high_rate));
    chk("single", 16'h1, 16'(reply.single_subcarrier));
    go(8'h04, 8'hA1, 8'h80, 8'h0, 8'h0, 8'h0, 8'h0);
    chk("lo_rate", 16'h0, 16'(reply.high_rate));
    go(8'h40, 8'hA0, 8'hC0, 8'h02, 8'h03, 8'h01, 8'h20);
    chk("slot1", 16'h1, 16'(reply.first_slot_only));
    chk("a_nblk", 16'h2, 16'(reply.n_blocks));
    go(8'h00, 8'hA0, 8'h80, 8'h0, 8'h0, 8'h0, 8'hD0);
    chk("sel_state", 16'h1, 16'(tag_state_code));
    chk("sel_rsp", 16'h1, 16'(reply.respond));
    go(8'h04, 8'hA0, 8'h80, 8'h0, 8'h0, 8'h0, 8'h00);
    chk("sel_inv", 16'h1, 16'(reply.respond));
    go(8'h00, 8'hA0, 8'h80, 8'h0, 8'h0, 8'h0, 8'h50);
    chk("unsel", 16'h0, 16'(reply.respond));
  endtask
  initial begin
    rst();
    t_bus();
    t_ext();
    t_alarm();
    t_quiet();
    t_fast_addr();
    finish_test();
  end
  // About 23 requests of 13 cycles each; wide margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    finish_test();
  end
endmodule // inventory_read_extended_handler_tb

bind inventory_read_extended_handler inv_read_monitor #(.LAST_USER_BLOCK(LAST_USER_BLOCK)) i_mon (
  .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .reply, .reply_valid);
